// *** stmc_pkg.sv ***
// package of the scan and test mode control block: field positions,
// decode codes, reset values and carrier structs.
// assumes one core clock; no other package is needed.
package stmc_pkg;

  // ---------------------------------------------------------------
  // scan chain shape
  // ---------------------------------------------------------------
  localparam int CHAIN_CNT = 7;
  localparam int CHAIN_LEN = 8;
  localparam int DBG_CNT_W = 8;

  // ---------------------------------------------------------------
  // coprocessor transfer field positions
  // ---------------------------------------------------------------
  localparam int OP1_LSB  = 21;
  localparam int DIR_BIT  = 20;
  localparam int CRN_LSB  = 16;
  localparam int CPN_LSB  = 8;
  localparam int OP2_LSB  = 5;
  localparam int CRM_LSB  = 0;

  // ---------------------------------------------------------------
  // decode codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CPN_SYSCTL = 4'hf;
  localparam logic [3:0] CRN_TEST   = 4'hf;
  localparam logic [2:0] OP1_TREG   = 3'h7;
  localparam logic [3:0] CRM_TREG   = 4'hf;
  localparam logic [2:0] OP2_TREG   = 3'h7;
  localparam logic       DIR_WRITE  = 1'b1;

  // ---------------------------------------------------------------
  // register layout and reset values
  // ---------------------------------------------------------------
  localparam int         TREG_BIT   = 0;
  localparam logic       TREG_RESET = 1'b0;

  // ---------------------------------------------------------------
  // carrier structs
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] wdata;
  } stmc_cp_req_t;

  typedef struct packed {
    logic        rd_valid;
    logic [31:0] rdata;
    logic        op_go;
    logic        op_refused;
    logic        op_write;
    logic [10:0] op_sel;
  } stmc_cp_rsp_t;

  typedef struct packed {
    logic                                 test_mode_enable;
    stmc_cp_rsp_t                         rsp;
    logic [CHAIN_CNT-1:0][CHAIN_LEN-1:0] chain;
    logic [CHAIN_LEN-1:0]                 wrap;
    logic                                 clk_run;
    logic                                 bus_edge;
    logic                                 scan_misuse;
  } stmc_state_t;

endpackage

// *** stmc_scan_test_ctrl.sv ***
// scan and test mode control: production scan chains, wrapper chain,
// coprocessor-reached test state bit and gating of cache/MMU test ops.
// assumes all inputs synchronous to core_clk; debug reset asynchronous.
`timescale 1ns/1ps
`default_nettype none

module stmc_scan_test_ctrl (
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  input  wire logic                          system_reset_n,
  input  wire logic                          debug_state_reset_n,
  input  wire logic                          bus_clock_qualifier,
  input  wire logic                          debug_clock_qualifier,
  input  wire logic                          scan_clock_test_enable,
  input  wire logic                          scan_shift_enable,
  input  wire logic [stmc_pkg::CHAIN_CNT-1:0] scan_chain_serial_inputs,
  output var  logic [stmc_pkg::CHAIN_CNT-1:0] scan_chain_serial_outputs,
  input  wire logic                          wrap_scan_in,
  input  wire logic                          wrap_shift_enable,
  output var  logic                          wrap_scan_out,
  input  wire stmc_pkg::stmc_cp_req_t        cp_req,
  output var  stmc_pkg::stmc_cp_rsp_t        cp_rsp,
  output var  logic                          test_mode_enable,
  output var  logic                          internal_clk_run,
  output var  logic                          bus_edge_next,
  output var  logic                          scan_misuse,
  output var  logic [stmc_pkg::DBG_CNT_W-1:0] debug_tick_count
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  stmc_pkg::stmc_state_t        st_r;
  stmc_pkg::stmc_state_t        st_nxt;
  logic [stmc_pkg::DBG_CNT_W-1:0] dbg_cnt_r;

  // ---------------------------------------------------------------
  // coprocessor field extraction
  // ---------------------------------------------------------------
  logic [2:0] f_op1;
  logic       f_dir;
  logic [3:0] f_crn;
  logic [3:0] f_cpn;
  logic [2:0] f_op2;
  logic [3:0] f_crm;
  logic       is_c15;
  logic       is_treg;
  logic       is_write;

  assign f_op1    = cp_req.instr[stmc_pkg::OP1_LSB +: 3];
  assign f_dir    = cp_req.instr[stmc_pkg::DIR_BIT];
  assign f_crn    = cp_req.instr[stmc_pkg::CRN_LSB +: 4];
  assign f_cpn    = cp_req.instr[stmc_pkg::CPN_LSB +: 4];
  assign f_op2    = cp_req.instr[stmc_pkg::OP2_LSB +: 3];
  assign f_crm    = cp_req.instr[stmc_pkg::CRM_LSB +: 4];
  // c15 test space of the system control coprocessor
  assign is_c15   = cp_req.valid && (f_cpn == stmc_pkg::CPN_SYSCTL)
                    && (f_crn == stmc_pkg::CRN_TEST);
  assign is_write = (f_dir == stmc_pkg::DIR_WRITE);
  assign is_treg  = is_c15 && (f_op1 == stmc_pkg::OP1_TREG)
                    && (f_crm == stmc_pkg::CRM_TREG)
                    && (f_op2 == stmc_pkg::OP2_TREG);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp.rd_valid   = 1'b0;
    st_nxt.rsp.op_go      = 1'b0;
    st_nxt.rsp.op_refused = 1'b0;
    st_nxt.rsp.op_write   = 1'b0;

    // test state register: only bit 0 kept, upper write bits dropped
    if (is_treg && is_write) begin
      st_nxt.test_mode_enable = cp_req.wdata[stmc_pkg::TREG_BIT];
    end
    if (is_treg && !is_write) begin
      st_nxt.rsp.rd_valid = 1'b1;
      st_nxt.rsp.rdata    = {31'h0, st_r.test_mode_enable};
    end

    // other c15 ops are cache/MMU tests, passed on only when enabled
    if (is_c15 && !is_treg) begin
      st_nxt.rsp.op_sel   = {1'b0, f_op1, f_crm, f_op2};
      st_nxt.rsp.op_write = is_write;
      if (st_r.test_mode_enable) begin
        st_nxt.rsp.op_go = 1'b1;
      end else begin
        st_nxt.rsp.op_refused = 1'b1;
      end
    end

    // scan shift through all production chains at once
    if (scan_shift_enable) begin
      for (int i = 0; i < stmc_pkg::CHAIN_CNT; i++) begin
        st_nxt.chain[i] = {st_r.chain[i][stmc_pkg::CHAIN_LEN-2:0],
                           scan_chain_serial_inputs[i]};
      end
    end

    // boundary wrapper chain, numbered zero, has its own shift
    if (wrap_shift_enable) begin
      st_nxt.wrap = {st_r.wrap[stmc_pkg::CHAIN_LEN-2:0], wrap_scan_in};
    end

    // clock module enable: test enable is its only test input
    st_nxt.clk_run     = scan_clock_test_enable || system_reset_n;
    st_nxt.bus_edge    = bus_clock_qualifier;
    st_nxt.scan_misuse = scan_shift_enable && !scan_clock_test_enable;

    // system reset clears processor and bus side state
    if (!system_reset_n) begin
      st_nxt.test_mode_enable = stmc_pkg::TREG_RESET;
      st_nxt.rsp              = '0;
      st_nxt.bus_edge         = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // debug state: the debug scan path stops here, no expansion input
  always_ff @(posedge core_clk or negedge debug_state_reset_n) begin
    if (!debug_state_reset_n) begin
      dbg_cnt_r <= '0;
    end else if (srst) begin
      dbg_cnt_r <= '0;
    end else if (debug_clock_qualifier) begin
      dbg_cnt_r <= dbg_cnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  generate
    for (genvar g = 0; g < stmc_pkg::CHAIN_CNT; g++) begin : g_out
      assign scan_chain_serial_outputs[g] =
        st_r.chain[g][stmc_pkg::CHAIN_LEN-1];
    end
  endgenerate

  assign wrap_scan_out    = st_r.wrap[stmc_pkg::CHAIN_LEN-1];
  assign cp_rsp           = st_r.rsp;
  assign test_mode_enable = st_r.test_mode_enable;
  assign internal_clk_run = st_r.clk_run;
  assign bus_edge_next    = st_r.bus_edge;
  assign scan_misuse      = st_r.scan_misuse;
  assign debug_tick_count = dbg_cnt_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_treg_write_lands: assert property (
    (is_treg && is_write && system_reset_n)
      |=> (test_mode_enable == $past(cp_req.wdata[0])))
    else $error("test bit not updated by write");

  a_reset_clears_bit: assert property (
    !system_reset_n |=> !test_mode_enable)
    else $error("test bit not cleared under system reset");

  a_read_returns_bit: assert property (
    (is_treg && !is_write && system_reset_n)
      |=> (cp_rsp.rd_valid && cp_rsp.rdata == {31'h0, $past(test_mode_enable)}))
    else $error("test register read wrong");

  a_read_dir_only: assert property (
    (is_treg && is_write) |=> !cp_rsp.rd_valid)
    else $error("write answered as a read");

  a_op_gated_bit: assert property (
    cp_rsp.op_go |-> $past(test_mode_enable))
    else $error("test op passed while disabled");

  a_op_refused_bit: assert property (
    (is_c15 && !is_treg && !test_mode_enable && system_reset_n)
      |=> (cp_rsp.op_refused && !cp_rsp.op_go))
    else $error("test op not refused while disabled");

  a_chain_shift_len: assert property (
    scan_shift_enable [*8]
      |=> (scan_chain_serial_outputs[0] == $past(scan_chain_serial_inputs[0], 8)))
    else $error("chain shift latency wrong");

  a_chain_hold: assert property (
    !scan_shift_enable |=> $stable(scan_chain_serial_outputs))
    else $error("chains moved without shift enable");

  a_clock_free_run: assert property (
    scan_clock_test_enable |=> internal_clk_run)
    else $error("clocks not free-running in test");

  a_bus_edge_mark: assert property (
    (system_reset_n && bus_clock_qualifier) |=> bus_edge_next)
    else $error("bus edge not marked");

  a_dbg_count_step: assert property (
    @(posedge core_clk) disable iff (!debug_state_reset_n || srst)
    debug_clock_qualifier |=> (debug_tick_count == $past(debug_tick_count) + 8'h01))
    else $error("debug state did not advance");

endmodule

`default_nettype wire

// *** stmc_tester.sv ***
// partner model: scan tester and test software pins of the block.
// assumes the bench sets the mode and requests at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module stmc_tester (
  input  wire logic scan_mode,
  input  wire logic shift_req,
  input  wire logic func_dbg_q,
  output logic      scan_clock_test_enable,
  output logic      scan_shift_enable,
  output logic      debug_clock_qualifier
);
  // test enable high for the whole scan session, low in functional use
  assign scan_clock_test_enable = scan_mode;
  // shifting only ever requested inside a scan session
  assign scan_shift_enable = scan_mode & shift_req;
  // single tap in this model, nothing chained behind the core
  // debug qualifier held high while scanning, free in functional use
  assign debug_clock_qualifier = scan_mode | func_dbg_q;
endmodule
`default_nettype wire

// *** stmc_scan_test_ctrl_bench.sv ***
// bench: drives the block as processor and tester, checks its answers.
// assumes the package and the tester model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module stmc_scan_test_ctrl_bench;
  localparam int N = stmc_pkg::CHAIN_CNT;
  localparam int L = stmc_pkg::CHAIN_LEN;
  localparam logic [9:0] OPS [6] = '{10'h0ba, 10'h0be, 10'h0da, 10'h0de, 10'h0bd, 10'h198};
  logic core_clk, srst = 1, sys_n = 1, dbg_n = 1, bus_q = 0, mode = 0, shreq = 0;
  logic fdq = 0, wsh = 0, win = 0, tm = 0, tme, crun, bedge, misuse, wout, sce, sse, dq;
  logic bq_d, cr_d;
  logic [N-1:0] sin = '0, sout;
  logic [7:0] dcnt, dc;
  logic [N-1:0][L-1:0] cm;
  logic [L-1:0] wm;
  logic [31:0] rs = 32'hf9a8, r;
  int err_count = 0, check_count = 0, nsh = 0, nw = 0;
  stmc_pkg::stmc_cp_req_t req = '0;
  stmc_pkg::stmc_cp_rsp_t rsp;
  logic [45:0] exq [$];

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic [45:0] mk(logic v, logic [31:0] d, logic g, logic f, logic w,
                                     logic [10:0] s);
    return {v, v ? d : 32'h0, g, f, w, (g | f) ? s[9:0] : 10'h0};
  endfunction

  wire logic [45:0] got = mk(rsp.rd_valid, rsp.rdata, rsp.op_go, rsp.op_refused,
                             rsp.op_write, rsp.op_sel);
  wire logic [9:0] sel = {req.instr[23:21], req.instr[3:0], req.instr[7:5]};
  wire logic hit = req.valid && req.instr[11:8] == 4'hf && req.instr[19:16] == 4'hf;

  stmc_tester TST (.scan_mode(mode), .shift_req(shreq), .func_dbg_q(fdq),
    .scan_clock_test_enable(sce), .scan_shift_enable(sse), .debug_clock_qualifier(dq));
  stmc_scan_test_ctrl DUT (.core_clk(core_clk), .srst(srst), .system_reset_n(sys_n),
    .debug_state_reset_n(dbg_n), .bus_clock_qualifier(bus_q), .debug_clock_qualifier(dq),
    .scan_clock_test_enable(sce), .scan_shift_enable(sse), .scan_chain_serial_inputs(sin),
    .scan_chain_serial_outputs(sout), .wrap_scan_in(win), .wrap_shift_enable(wsh),
    .wrap_scan_out(wout), .cp_req(req), .cp_rsp(rsp), .test_mode_enable(tme),
    .internal_clk_run(crun), .bus_edge_next(bedge), .scan_misuse(misuse),
    .debug_tick_count(dcnt));

  task automatic chk(input logic [45:0] g, input logic [45:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one transfer per call, valid held for back-to-back calls
  task automatic cp(input logic [9:0] s, input logic d, input logic [7:0] nc,
                    input logic [31:0] wd);
    req.valid = 1'b1;
    req.instr = {8'h00, s[9:7], d, nc[7:4], 4'h0, nc[3:0], s[2:0], 1'b0, s[6:3]};
    req.wdata = wd;
    @(negedge core_clk);
  endtask

  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end

  always @(negedge core_clk) begin
    r = xs();
    sin <= r[N-1:0];
    win <= r[7];
    wsh <= r[8];
    bus_q <= r[9];
    fdq <= r[10];
  end

  // reference of the block, with expected answers queued
  always @(posedge core_clk) begin
    bq_d <= (srst | !sys_n) ? 1'b0 : bus_q;
    cr_d <= srst ? 1'b0 : (sce | sys_n);
    if (srst | !sys_n)
      tm <= 1'b0;
    else if (hit && sel == 10'h3ff && req.instr[20])
      tm <= req.wdata[0];
    if (hit && sys_n && !srst) begin
      if (sel != 10'h3ff)
        exq.push_back(mk(1'b0, 32'h0, tm, !tm, req.instr[20], {1'b0, sel}));
      else if (!req.instr[20])
        exq.push_back(mk(1'b1, {31'h0, tm}, 1'b0, 1'b0, 1'b0, 11'h0));
    end
    if (sse) begin
      for (int i = 0; i < N; i++)
        cm[i] <= {cm[i][L-2:0], sin[i]};
      nsh <= nsh + 1;
    end
    if (wsh && !srst) begin
      wm <= {wm[L-2:0], win};
      nw <= nw + 1;
    end
  end

  always @(posedge core_clk or negedge dbg_n)
    if (!dbg_n)
      dc <= 8'h00;
    else
      dc <= srst ? 8'h00 : dc + {7'h0, dq};

  always @(negedge core_clk) if (!srst) begin
    chk(bedge, bq_d);
    chk(crun, cr_d);
    chk(misuse, 1'b0);
    chk(dcnt, dc);
    chk(tme, tm);
    if (nsh >= L)
      for (int i = 0; i < N; i++) chk(sout[i], cm[i][L-1]);
    if (nw >= L)
      chk(wout, wm[L-1]);
    if (rsp.rd_valid | rsp.op_go | rsp.op_refused)
      chk(got, exq.size() ? exq.pop_front() : 46'h0);
  end

  initial begin
    #5us;
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    cp(10'h3ff, 1'b0, 8'hff, 32'h0);
    cp(OPS[0], 1'b1, 8'hff, xs());
    cp(10'h3ff, 1'b1, 8'hff, 32'hffff_fffe);
    cp(10'h3ff, 1'b1, 8'hef, 32'h1);
    cp(10'h3ff, 1'b1, 8'hfe, 32'h1);
    cp(10'h3ff, 1'b1, 8'hff, xs() | 32'h1);
    cp(10'h3ff, 1'b0, 8'hff, 32'h0);
    foreach (OPS[i]) cp(OPS[i], 1'b1, 8'hff, xs());
    req.valid = 1'b0;
    repeat (3) @(negedge core_clk);
    sys_n = 1'b0;
    cp(OPS[1], 1'b1, 8'hff, 32'h0);
    req.valid = 1'b0;
    @(negedge core_clk);
    sys_n = 1'b1;
    cp(OPS[2], 1'b1, 8'hff, 32'h0);
    req.valid = 1'b0;
    #3 dbg_n = 1'b0;
    #1 chk(dcnt, 8'h00);
    @(negedge core_clk);
    dbg_n = 1'b1;
    mode = 1'b1;
    shreq = 1'b1;
    repeat (40) @(negedge core_clk);
    shreq = 1'b0;
    repeat (6) @(negedge core_clk);
    mode = 1'b0;
    repeat (2) @(negedge core_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
